// >>> rtl/pd_pkg.sv
package pd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SPACING_NS    = 10;
  // least spacing rounds up, never below one cycle
  localparam int SPACING_RAW =
    (SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPACING_CYC = (SPACING_RAW < 1) ? 1 : SPACING_RAW;
  localparam int INIT_WAIT_CYC = 2;
  localparam int CNT_W         = 8;
  localparam logic [CNT_W-1:0] SPACING_RESET = CNT_W'(SPACING_CYC);
  localparam logic [1:0]       INIT_WAIT_LAST = 2'(INIT_WAIT_CYC - 1);

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_SPACING_LSB = 0;
  localparam int STAT_STATE_LSB   = 0;
  localparam int STAT_MODE_LSB    = 4;
  localparam int STAT_VALID_BIT   = 6;
  localparam int STAT_STANDBY_BIT = 8;
  localparam int STAT_USER_BIT    = 9;
  localparam int STAT_INITOK_BIT  = 10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLAVE_SERIAL  = 2'h0,
    MODE_MASTER_SERIAL = 2'h1,
    MODE_EXPRESS       = 2'h2
  } load_mode_t;

  typedef enum logic [3:0] {
    ST_CLEAR    = 4'h0,
    ST_INITWAIT = 4'h1,
    ST_LOAD     = 4'h2,
    ST_DONEWAIT = 4'h3,
    ST_USER     = 4'h4,
    ST_SBIN     = 4'h5,
    ST_SBHOLD   = 4'h6,
    ST_SBREL    = 4'h7,
    ST_SBOUT    = 4'h8
  } pd_state_t;

  // mode pins: 11 slave serial, 10 master serial, 0X express
  function automatic load_mode_t decode_mode(input logic [1:0] ms);
    if (!ms[1])
      return MODE_EXPRESS;
    else if (ms[0])
      return MODE_SLAVE_SERIAL;
    else
      return MODE_MASTER_SERIAL;
  endfunction

endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import pd_pkg::*;
#(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t r;
  sync_t next_r;

  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_r    = r;
    next_r.s1 = pinIn;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i])
        next_r.q[i] = r.s3[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    else
      r <= next_r;
  end

  assign pinOut = r.q;

endmodule // pin_sync
`default_nettype wire

// >>> rtl/step_timer.sv
`timescale 1ns/1ps
`default_nettype none
module step_timer
  import pd_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  expired
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             expired;
  } timer_t;

  timer_t r;
  timer_t next_r;

  // ----------------------------------------------------------------
  // expired pulses load cycles after start; zero acts as one
  // ----------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.expired = 1'b0;
    if (start) begin
      next_r.busy = 1'b1;
      next_r.cnt  = (load == '0) ? CNT_W'(1) : load;
    end else if (r.busy) begin
      next_r.cnt = r.cnt - CNT_W'(1);
      if (r.cnt <= CNT_W'(1)) begin
        next_r.busy    = 1'b0;
        next_r.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      r <= '0;
    else
      r <= next_r;
  end

  assign expired = r.expired;

endmodule // step_timer
`default_nettype wire

// >>> rtl/standby_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module standby_sequencer
  import pd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              standbyPinN,
  input  wire logic              reconfigPinN,
  input  wire logic [1:0]        modeSelectPin,
  input  wire logic              donePinIn,
  input  wire logic              initPinIn,
  input  wire logic              configClockPin,
  input  wire logic              configLoadDone,
  output logic                   inputBufEnable,
  output logic                   outputBufEnable,
  output logic                   globalSetReset,
  output logic                   globalOutputFloat,
  output logic                   pullupEnable,
  output logic                   modePullupEnable,
  output logic                   standbyPullupEnable,
  output logic                   boundaryScanEnable,
  output logic      [1:0]        modeSelectSeen,
  output logic                   doneSeen,
  output logic                   configClockSeen,
  output logic      [1:0]        loadMode,
  output logic                   modeValid,
  output logic                   configStart,
  output logic                   configRestart,
  output logic                   doneOut,
  output logic                   doneOe,
  output logic                   initOut,
  output logic                   initOe,
  output logic                   userIoActive,
  output logic                   initStatusValid
);

  typedef struct packed {
    pd_state_t        state;
    logic             wasUser;
    logic [1:0]       waitCnt;
    logic [CNT_W-1:0] spacing;
    logic             waitreq;
    logic [31:0]      rdata;
    logic             inEn;
    logic             outEn;
    logic             global_set_reset;
    logic             global_output_float;
    logic             pullEn;
    logic             modePull;
    logic             sbPull;
    logic             bscanEn;
    logic [1:0]       modeSeen;
    logic             doneSeen;
    logic             initSeen;
    logic             clkSeen;
    load_mode_t       mode;
    logic             modeValid;
    logic             cfgStart;
    logic             cfgRestart;
    logic             doneOe;
    logic             initOe;
    logic             userIo;
    logic             initOk;
  } pd_t;

  pd_t        r;
  pd_t        next_r;
  logic [6:0] pinSync;
  logic       timerStart;
  logic       timerExpired;
  logic       standby;
  logic       reconfig;

  // ----------------------------------------------------------------
  // pin synchronisers and spacing timer
  // ----------------------------------------------------------------
  // idle pin levels at reset so nothing looks like standby or request
  pin_sync #(
    .W       (7),
    .RST_VAL (7'h03)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pinIn   ({configClockPin, initPinIn, donePinIn, modeSelectPin,
                reconfigPinN, standbyPinN}),
    .pinOut  (pinSync)
  );

  step_timer u_timer (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (timerStart),
    .load    (r.spacing),
    .expired (timerExpired)
  );

  assign standby  = !pinSync[0];
  assign reconfig = !pinSync[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r            = r;
    timerStart        = 1'b0;
    next_r.cfgStart   = 1'b0;
    next_r.cfgRestart = 1'b0;
    // the standby pin itself never loses its pull-up
    next_r.sbPull     = 1'b1;
    // gated views: buffers off means every input reads low
    next_r.modeSeen = r.inEn ? pinSync[3:2] : 2'h0;
    next_r.doneSeen = r.inEn & pinSync[4];
    next_r.initSeen = r.inEn & pinSync[5];
    next_r.clkSeen  = r.inEn & pinSync[6];

    // register bus: one wait cycle, then a single acknowledge cycle
    next_r.waitreq = !((avs_read || avs_write) && r.waitreq);
    if (avs_read && r.waitreq) begin
      next_r.rdata = 32'h0;
      if (avs_address == REG_CTRL)
        next_r.rdata[CTRL_SPACING_LSB +: CNT_W] = r.spacing;
      else if (avs_address == REG_STATUS) begin
        next_r.rdata[STAT_STATE_LSB +: 4]  = r.state;
        next_r.rdata[STAT_MODE_LSB +: 2]   = r.mode;
        next_r.rdata[STAT_VALID_BIT]       = r.modeValid;
        next_r.rdata[STAT_STANDBY_BIT]     = standby;
        next_r.rdata[STAT_USER_BIT]        = r.userIo;
        next_r.rdata[STAT_INITOK_BIT]      = r.initOk;
      end
    end
    if (avs_write && !r.waitreq && avs_address == REG_CTRL)
      next_r.spacing = avs_writedata[CTRL_SPACING_LSB +: CNT_W];

    case (r.state)
      // configuration memory clear: hold init low while request stands
      ST_CLEAR: begin
        // keep driving until our own low has come back through the
        // synchroniser, else a stale high would skip the init handshake
        next_r.initOe  = reconfig || (r.initOe && r.initSeen);
        next_r.waitCnt = 2'h0;
        if (!reconfig && !r.initOe && r.initSeen)
          next_r.state = ST_INITWAIT;
      end
      // two clocks after init reads high, take the mode once
      ST_INITWAIT: begin
        next_r.waitCnt = r.waitCnt + 2'h1;
        if (r.waitCnt == INIT_WAIT_LAST) begin
          next_r.mode      = decode_mode(r.modeSeen);
          next_r.modeValid = 1'b1;
          next_r.cfgStart  = 1'b1;
          next_r.state     = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (configLoadDone) begin
          next_r.doneOe = 1'b0; // release open-drain completion
          next_r.state  = ST_DONEWAIT;
        end
      end
      // a shared completion line holds everyone until the last is done;
      // an open pin floats high at once via its pull-up
      ST_DONEWAIT: begin
        next_r.modePull = 1'b0;
        if (r.doneSeen) begin
          next_r.userIo = 1'b1;
          next_r.global_output_float    = 1'b0;
          next_r.global_set_reset    = 1'b0;
          next_r.state  = ST_USER;
        end
      end
      ST_USER: begin
        next_r.modePull = 1'b0;
      end
      // inputs and set/reset are already switched; outputs follow
      ST_SBIN: begin
        if (timerExpired) begin
          next_r.outEn = 1'b0;
          next_r.global_output_float   = 1'b1;
          next_r.state = ST_SBHOLD;
        end
      end
      ST_SBHOLD: begin
        if (!standby) begin
          next_r.inEn    = 1'b1;
          next_r.pullEn  = 1'b1;
          next_r.bscanEn = 1'b1;
          next_r.state   = ST_SBREL;
        end
      end
      // set/reset goes right after the inputs if wasUser, else stays asserted; start output spacing
      ST_SBREL: begin
        next_r.global_set_reset   = !r.wasUser;
        timerStart   = 1'b1;
        next_r.state = ST_SBOUT;
      end
      ST_SBOUT: begin
        if (timerExpired) begin
          next_r.outEn = 1'b1;
          if (r.wasUser) begin
            next_r.global_output_float    = 1'b0;
            next_r.userIo = 1'b1;
            next_r.state  = ST_USER;
          end else begin
            // interrupted or never started: load again from scratch
            next_r.cfgRestart = 1'b1;
            next_r.modeValid  = 1'b0;
            next_r.modePull   = 1'b1;
            next_r.doneOe     = 1'b1;
            next_r.initOe     = 1'b1;
            next_r.initOk     = 1'b1;
            next_r.state      = ST_CLEAR;
          end
        end
      end
      default: begin
        next_r.state = ST_CLEAR;
      end
    endcase

    // reconfiguration request: acts in every state, standby included;
    // in standby it only forgets the loaded design for the exit path
    if (reconfig && r.state != ST_CLEAR) begin
      if (r.state inside {ST_SBIN, ST_SBHOLD, ST_SBREL, ST_SBOUT}) begin
        next_r.wasUser = 1'b0;
        next_r.initOk  = 1'b0;
      end else begin
        next_r.state      = ST_CLEAR;
        next_r.cfgRestart = 1'b1;
        next_r.global_set_reset        = 1'b1;
        next_r.global_output_float        = 1'b1;
        next_r.userIo     = 1'b0;
        next_r.modeValid  = 1'b0;
        next_r.modePull   = 1'b1;
        next_r.doneOe     = 1'b1;
        next_r.initOe     = 1'b1;
      end
    end

    // standby entry from any running state; the loaded design stays,
    // combinational paths keep running on the forced-low inputs
    if (standby && !(r.state inside {ST_SBIN, ST_SBHOLD})) begin
      if (!(r.state inside {ST_SBREL, ST_SBOUT}))
        next_r.wasUser = (r.state == ST_USER) && !reconfig;
      next_r.initOk   = next_r.wasUser || r.state inside
                        {ST_SBREL, ST_SBOUT} && r.wasUser;
      next_r.inEn     = 1'b0;
      next_r.global_set_reset      = 1'b1;
      next_r.pullEn   = 1'b0;
      next_r.modePull = 1'b0;
      next_r.bscanEn  = 1'b0;
      next_r.doneOe   = 1'b0;
      next_r.initOe   = 1'b0;
      next_r.userIo   = 1'b0;
      timerStart      = 1'b1;
      next_r.state    = ST_SBIN;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r          <= '0;
      r.state    <= ST_CLEAR;
      r.spacing  <= SPACING_RESET;
      r.waitreq  <= 1'b1;
      r.inEn     <= 1'b1;
      r.outEn    <= 1'b1;
      r.global_set_reset      <= 1'b1;
      r.global_output_float      <= 1'b1;
      r.pullEn   <= 1'b1;
      r.modePull <= 1'b1;
      r.sbPull   <= 1'b1;
      r.bscanEn  <= 1'b1;
      r.doneOe   <= 1'b1;
      r.initOe   <= 1'b1;
      r.initOk   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata        = r.rdata;
  assign avs_waitrequest     = r.waitreq;
  assign inputBufEnable      = r.inEn;
  assign outputBufEnable     = r.outEn;
  assign globalSetReset      = r.global_set_reset;
  assign globalOutputFloat   = r.global_output_float;
  assign pullupEnable        = r.pullEn;
  assign modePullupEnable    = r.modePull;
  assign standbyPullupEnable = r.sbPull;
  assign boundaryScanEnable  = r.bscanEn;
  assign modeSelectSeen      = r.modeSeen;
  assign doneSeen            = r.doneSeen;
  assign configClockSeen     = r.clkSeen;
  assign loadMode            = r.mode;
  assign modeValid           = r.modeValid;
  assign configStart         = r.cfgStart;
  assign configRestart       = r.cfgRestart;
  assign doneOut             = 1'b0;
  assign doneOe              = r.doneOe;
  assign initOut             = 1'b0;
  assign initOe              = r.initOe;
  assign userIoActive        = r.userIo;
  assign initStatusValid     = r.initOk;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_buf_off;
    @(posedge sys_clk) disable iff (!rstn)
      r.state == ST_SBHOLD |-> !inputBufEnable && !outputBufEnable;
  endproperty
  a_buf_off: assert property (p_buf_off)
    else $error("buffers enabled while holding standby");

  property p_forced_low;
    @(posedge sys_clk) disable iff (!rstn)
      !inputBufEnable ##1 !inputBufEnable |-> modeSelectSeen == 2'h0
        && !doneSeen && !configClockSeen && !pullupEnable;
  endproperty
  a_forced_low: assert property (p_forced_low)
    else $error("input seen high or pull-up on in standby");

  property p_gsr_hold;
    @(posedge sys_clk) disable iff (!rstn)
      r.state inside {ST_SBIN, ST_SBHOLD} |-> globalSetReset;
  endproperty
  a_gsr_hold: assert property (p_gsr_hold)
    else $error("set/reset dropped during standby");

  property p_entry_order;
    @(posedge sys_clk) disable iff (!rstn)
      $fell(inputBufEnable) |-> globalSetReset && outputBufEnable
        ##1 outputBufEnable;
  endproperty
  a_entry_order: assert property (p_entry_order)
    else $error("outputs not held after inputs disabled");

  property p_exit_order;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(outputBufEnable) |-> inputBufEnable
        && $past(inputBufEnable, 2);
  endproperty
  a_exit_order: assert property (p_exit_order)
    else $error("outputs enabled before inputs");

  property p_restart;
    @(posedge sys_clk) disable iff (!rstn)
      r.state == ST_SBOUT && !r.wasUser && timerExpired && !standby
        |=> configRestart && r.state == ST_CLEAR;
  endproperty
  a_restart: assert property (p_restart)
    else $error("configuration not restarted after standby");

  property p_bscan_off;
    @(posedge sys_clk) disable iff (!rstn)
      r.state inside {ST_SBIN, ST_SBHOLD} |-> !boundaryScanEnable;
  endproperty
  a_bscan_off: assert property (p_bscan_off)
    else $error("boundary scan usable in standby");

  property p_mode_once;
    @(posedge sys_clk) disable iff (!rstn)
      modeValid && $past(modeValid) |-> $stable(loadMode);
  endproperty
  a_mode_once: assert property (p_mode_once)
    else $error("load mode changed after sampling");

  property p_user_after_done;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(userIoActive) && $past(r.state) == ST_DONEWAIT
        |-> $past(doneSeen);
  endproperty
  a_user_after_done: assert property (p_user_after_done)
    else $error("user I/O active before completion seen high");

endmodule // standby_sequencer
`default_nettype wire

// >>> testbench/sys_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sys_ctrl_model (
  input  wire logic sys_clk,
  input  wire logic standbyReq,
  input  wire logic extDoneHold,
  input  wire logic doneOe,
  input  wire logic initOe,
  output logic      standbyPinN,
  output logic      donePinIn,
  output logic      initPinIn,
  output logic      ready
);
  int lowCnt = 0;
  int relCnt = 0;
  // ------------------------------------------------------------
  // standby pin, stretched so a short request still lasts 3 cycles
  // ------------------------------------------------------------
  initial standbyPinN = 1'b1;
  always @(posedge sys_clk) begin
    if (standbyReq || (!standbyPinN && lowCnt < 3)) begin
      standbyPinN <= 1'b0;
      lowCnt <= lowCnt + 1;
    end else begin
      standbyPinN <= 1'b1;
      lowCnt <= 0;
    end
  end
  // no use of the device until 3 cycles after release
  always @(posedge sys_clk)
    relCnt <= !standbyPinN ? 0 : (relCnt < 3 ? relCnt + 1 : 3);
  assign ready = (relCnt == 3) && standbyPinN;
  // open-drain lines with board pull-ups; another chain member may hold done
  assign donePinIn = !(doneOe || extDoneHold);
  assign initPinIn = !initOe;
endmodule // sys_ctrl_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pd_pkg::*;
;
  logic              sys_clk, rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0, avs_readdata, q;
  logic              avs_waitrequest, reconfigPinN = 1'b1;
  logic [1:0]        modeSelectPin = 2'h3, modeSelectSeen, loadMode;
  logic              configClockPin = 1'b0, configLoadDone = 1'b0;
  logic              standbyReq = 1'b0, extDoneHold = 1'b0, ready;
  logic              standbyPinN, donePinIn, initPinIn, doneSeen;
  logic              inputBufEnable, outputBufEnable, globalSetReset;
  logic              globalOutputFloat, pullupEnable, modePullupEnable;
  logic              standbyPullupEnable, boundaryScanEnable, modeValid;
  logic              configClockSeen, configStart, configRestart;
  logic              doneOe, initOe, userIoActive, initStatusValid;
  int                n_fail = 0, checks = 0, n, c, g, o, ms, spacing;

  standby_sequencer standby_sequencer_i (
    .sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .standbyPinN, .reconfigPinN,
    .modeSelectPin, .donePinIn, .initPinIn, .configClockPin,
    .configLoadDone, .inputBufEnable, .outputBufEnable, .globalSetReset,
    .globalOutputFloat, .pullupEnable, .modePullupEnable,
    .standbyPullupEnable, .boundaryScanEnable, .modeSelectSeen, .doneSeen,
    .configClockSeen, .loadMode, .modeValid, .configStart, .configRestart,
    .doneOut(), .doneOe, .initOut(), .initOe, .userIoActive,
    .initStatusValid
  );
  sys_ctrl_model sys_ctrl_model_i (
    .sys_clk, .standbyReq, .extDoneHold, .doneOe, .initOe, .standbyPinN,
    .donePinIn, .initPinIn, .ready
  );

  // ------------------------------------------------------------
  // clock, toggling config clock pin, watchdog
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // slow enough for the agree-twice synchroniser to pass every level
  always begin
    repeat (4) @(posedge sys_clk);
    configClockPin <= ~configClockPin;
  end
  // the whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({24'h0, got}, {24'h0, exp});
  endtask
  // reference decode of the mode pins
  function automatic logic [1:0] exp_mode(input int m);
    if (m < 2)
      return MODE_EXPRESS;
    return (m == 3) ? MODE_SLAVE_SERIAL : MODE_MASTER_SERIAL;
  endfunction
  // one Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int i;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    r = avs_readdata;
    if (i >= 50)
      n_fail++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic reconfig();
    reconfigPinN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reconfigPinN <= 1'b1;
    for (n = 0; n < 200 && configStart !== 1'b1; n++) @(posedge sys_clk);
  endtask
  // enter standby; c returns cycles from inputs off to outputs off
  task automatic enter_sb();
    standbyReq <= 1'b1;
    for (n = 0; n < 20 && inputBufEnable !== 1'b0; n++) @(posedge sys_clk);
    chk_pin({globalSetReset, pullupEnable, boundaryScanEnable}, 3'h4);
    for (c = 0; c < 20 && outputBufEnable !== 1'b0; c++) @(posedge sys_clk);
    @(posedge sys_clk);
    chk_pin({modeSelectSeen, doneSeen, configClockSeen}, 4'h0);
    chk_pin({globalOutputFloat, standbyPullupEnable, initOe, doneOe}, 4'hC);
  endtask
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(93315));
    repeat (8) @(posedge sys_clk);
    chk_pin({avs_waitrequest, globalSetReset, globalOutputFloat}, 3'h7);
    rstn <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, REG_CTRL, '0, q);
    chk_reg(q, 32'h1);
    bus(1'b0, 4'h8, '0, q);
    chk_reg(q, 32'h0);
    // every mode code, pins moved after capture must not matter
    for (int k = 0; k < 4; k++) begin
      ms = k ^ 3;
      modeSelectPin <= 2'(ms);
      reconfig();
      chk_pin({modeValid, loadMode}, {1'b1, exp_mode(ms)});
      chk_pin(modePullupEnable, 1'b1);
      modeSelectPin <= ~2'(ms);
      repeat (6) @(posedge sys_clk);
      chk_pin(loadMode, exp_mode(ms));
    end
    // load done while another chain member still holds the done line
    extDoneHold <= 1'b1;
    configLoadDone <= 1'b1;
    @(posedge sys_clk);
    configLoadDone <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk_pin({userIoActive, doneOe}, 2'h0);
    extDoneHold <= 1'b0;
    for (n = 0; n < 20 && userIoActive !== 1'b1; n++) @(posedge sys_clk);
    chk_pin({globalSetReset, globalOutputFloat, modePullupEnable}, 3'h0);
    bus(1'b1, REG_STATUS, 32'hFFFFFFFF, q);
    bus(1'b0, REG_STATUS, '0, q);
    chk_reg(q, {21'h0, 5'h19, exp_mode(0), ST_USER});
    spacing = 1 + $urandom % 4;
    bus(1'b1, REG_CTRL, 32'(spacing), q);
    bus(1'b0, REG_CTRL, '0, q);
    chk_reg(q, 32'(spacing));
    // inputs pass while awake, so the forced-low checks can trip
    for (n = 0; n < 20 && configClockSeen !== 1'b1; n++) @(posedge sys_clk);
    chk_pin({modeSelectSeen, doneSeen, configClockSeen}, 4'hF);
    // standby from user mode, entered only once loading is over
    enter_sb();
    chk_reg(32'(c), 32'(spacing + 1));
    repeat (6) @(posedge sys_clk);
    chk_pin(globalSetReset, 1'b1);
    standbyReq <= 1'b0;
    for (n = 0; n < 20 && inputBufEnable !== 1'b1; n++) @(posedge sys_clk);
    for (g = 0; g < 20 && globalSetReset !== 1'b0; g++) @(posedge sys_clk);
    for (o = g; o < 20 && outputBufEnable !== 1'b1; o++) @(posedge sys_clk);
    chk_reg(32'(g), 32'h1);
    chk_reg(32'(o), 32'(spacing + 2));
    for (n = 0; n < 20 && ready !== 1'b1; n++) @(posedge sys_clk);
    chk_pin({userIoActive, globalOutputFloat}, 2'h2);
    // standby in the middle of loading forces a fresh configuration
    reconfig();
    enter_sb();
    chk_pin(initStatusValid, 1'b0);
    standbyReq <= 1'b0;
    for (n = 0; n < 40 && configRestart !== 1'b1; n++) @(posedge sys_clk);
    chk_pin(configRestart, 1'b1);
    for (n = 0; n < 200 && configStart !== 1'b1; n++) @(posedge sys_clk);
    chk_pin(configStart, 1'b1);
    // reconfiguration request inside standby still forgets the design
    configLoadDone <= 1'b1;
    @(posedge sys_clk);
    configLoadDone <= 1'b0;
    for (n = 0; n < 40 && userIoActive !== 1'b1; n++) @(posedge sys_clk);
    chk_pin(userIoActive, 1'b1);
    enter_sb();
    reconfigPinN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reconfigPinN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_pin(initStatusValid, 1'b0);
    standbyReq <= 1'b0;
    for (n = 0; n < 40 && configRestart !== 1'b1; n++) @(posedge sys_clk);
    chk_pin({configRestart, userIoActive}, 2'h2);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
